// *** rtl/synth_ctrl_pkg.sv ***
package synth_ctrl_pkg;

    // ------------
    // register offsets
    // ------------
    localparam logic [6:0] BLOCK_STANDBY_ADDR            = 7'h00;
    localparam logic [6:0] OSCILLATOR_BIAS_SELECT_ADDR   = 7'h01;
    localparam logic [6:0] LO_REF_DIVIDER_HIGH_ADDR      = 7'h08;
    localparam logic [6:0] LO_REF_DIVIDER_LOW_ADDR       = 7'h09;
    localparam logic [6:0] LO_SWALLOW_AND_MAIN_HIGH_ADDR = 7'h0a;
    localparam logic [6:0] LO_MAIN_COUNT_LOW_ADDR        = 7'h0b;
    localparam logic [6:0] LO_PUMP_CONTROL_ADDR          = 7'h0c;
    localparam logic [6:0] LO_FASTACQ_DIVISOR_HIGH_ADDR  = 7'h0d;
    localparam logic [6:0] LO_FASTACQ_DIVISOR_LOW_ADDR   = 7'h0e;
    localparam logic [6:0] CLK_REF_DIVIDER_HIGH_ADDR     = 7'h10;
    localparam logic [6:0] CLK_REF_DIVIDER_LOW_ADDR      = 7'h11;
    localparam logic [6:0] CLK_FEEDBACK_DIVIDER_HIGH_ADDR = 7'h12;
    localparam logic [6:0] CLK_FEEDBACK_DIVIDER_LOW_ADDR = 7'h13;
    localparam logic [6:0] CLK_PUMP_CONTROL_ADDR         = 7'h14;
    localparam logic [6:0] CLK_FASTACQ_DIVISOR_HIGH_ADDR = 7'h15;
    localparam logic [6:0] CLK_FASTACQ_DIVISOR_LOW_ADDR  = 7'h16;

    // ------------
    // reset values
    // ------------
    localparam logic [7:0]  BLOCK_STANDBY_RST   = 8'hff;
    localparam logic [1:0]  OSC_BIAS_RST        = 2'h0;
    localparam logic [13:0] REF_DIVIDER_RST     = 14'h0038;
    localparam logic [2:0]  LO_SWALLOW_RST      = 3'h5;
    localparam logic [12:0] LO_MAIN_RST         = 13'h001d;
    localparam logic [7:0]  PUMP_CONTROL_RST    = 8'h00;
    localparam logic [13:0] FASTACQ_DIVISOR_RST = 14'h0004;
    localparam logic [12:0] CLK_FEEDBACK_RST    = 13'h003c;

    // ------------
    // field positions
    // ------------
    localparam int SB_LO_BIT         = 6;
    localparam int SB_OSC_BIT        = 5;
    localparam int SB_CK_BIT         = 4;
    localparam int OSC_BIAS_LSB      = 2;
    localparam int SWALLOW_LSB       = 5;
    localparam int PUMP_FA_EN_BIT    = 6;
    localparam int PUMP_INVERT_BIT   = 5;
    localparam int PUMP_CODE_LSB     = 2;
    localparam int PUMP_TEST_LSB     = 0;

    // ------------
    // widths, serial frame and pump limits
    // ------------
    localparam int REF_W        = 14;
    localparam int FB_W         = 13;
    localparam int FRAME_W      = 16;
    localparam int ADDR_MSB     = 14;
    localparam int ADDR_LSB     = 8;
    localparam int UNITS_W      = 4;
    localparam logic [3:0] MAX_UNITS  = 4'h8;
    localparam logic [3:0] FA_FLOOR   = 4'h2;
    localparam real PUMP_STEP_MA      = 0.625;

    // ------------
    // carriers
    // ------------
    typedef struct packed {
        logic               up;
        logic               dn;
        logic               drive_en;
        logic [UNITS_W-1:0] units;
    } pump_drive_t;

    typedef struct packed {
        logic             fast_acq_enable;
        logic             phase_invert;
        logic [2:0]       current_code;
        logic [1:0]       test_select;
    } pump_ctl_t;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_HEAD,
        SPI_WDATA,
        SPI_RDATA
    } spi_state_t;

endpackage

// *** rtl/fast_acq_chan.sv ***
`timescale 1ns/1ns
module fast_acq_chan
    import synth_ctrl_pkg::*;
#(
    parameter int DIV_W = REF_W
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    // synchronised comparator pulses
    input  wire logic             up_in,
    input  wire logic             dn_in,
    // settings
    input  wire logic [DIV_W-1:0] divisor_in,
    input  wire pump_ctl_t        ctl_in,
    input  wire logic             standby_in,
    // pump drive
    output pump_drive_t           pump_out
);

    if (DIV_W < 2 || DIV_W > 16) begin : g_chk
        $error("fast_acq_chan: DIV_W out of range");
    end

    // ------------------------------------------------------------
    // pulse width in whole T periods
    // ------------------------------------------------------------
    logic [DIV_W-1:0]   cyc_ff;
    logic [2:0]         per_ff;
    logic [UNITS_W-1:0] mult_ff;
    logic               prev_ff;
    pump_drive_t        pump_ff;

    wire               pulse     = up_in | dn_in;
    wire [DIV_W-1:0]   div_eff   = (divisor_in == '0) ? DIV_W'(1) : divisor_in;
    wire               tick      = pulse && (cyc_ff == div_eff - DIV_W'(1));
    wire               pulse_end = prev_ff && !pulse;
    wire [DIV_W-1:0]   nxt_cyc   = (!pulse || tick) ? '0 : cyc_ff + DIV_W'(1);
    wire [2:0]         nxt_per   = !pulse ? 3'h0 :
                                   (tick && per_ff != 3'h7) ? per_ff + 3'h1 : per_ff;
    wire [UNITS_W-1:0] nxt_mult  = pulse_end ? UNITS_W'(per_ff) + UNITS_W'(1) : mult_ff;

    // ------------------------------------------------------------
    // instantaneous current units
    // ------------------------------------------------------------
    wire [UNITS_W-1:0] nominal  = UNITS_W'(ctl_in.current_code) + UNITS_W'(1);
    wire [UNITS_W-1:0] floor_u  = (ctl_in.current_code == 3'h0) ? FA_FLOOR : nominal;
    wire [UNITS_W-1:0] boosted  = (mult_ff > floor_u) ? mult_ff : floor_u;
    wire [UNITS_W-1:0] units    = ctl_in.fast_acq_enable ? boosted : nominal;
    wire               up_sel   = ctl_in.phase_invert ? dn_in : up_in;
    wire               dn_sel   = ctl_in.phase_invert ? up_in : dn_in;

    pump_drive_t nxt_pump;
    assign nxt_pump.up       = !standby_in && up_sel;
    assign nxt_pump.dn       = !standby_in && dn_sel;
    assign nxt_pump.drive_en = !standby_in;
    assign nxt_pump.units    = units;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            cyc_ff  <= '0;
            per_ff  <= 3'h0;
            mult_ff <= UNITS_W'(1);
            prev_ff <= 1'b0;
            pump_ff <= '0;
        end else begin
            cyc_ff  <= nxt_cyc;
            per_ff  <= nxt_per;
            mult_ff <= nxt_mult;
            prev_ff <= pulse;
            pump_ff <= nxt_pump;
        end
    end

    assign pump_out = pump_ff;

endmodule

// *** rtl/synth_charge_pump_ctrl.sv ***
`timescale 1ns/1ns
//
// Function
// - fast-acquire divisor divides reference into T
// - pulse over kT gives k+1 current steps, at most eight
// - boost applies only above nominal current
// - code zero with boost floors at twice
// - larger divisor lengthens T, less boost
// - clock synth: 14-bit reference, 13-bit feedback
// - clock pump current is (code+1) steps
// - clock fast acquire has own divisor
// - clock fast-acquire enable turns on boosting
// - clock synth standby disables on-chip synth
// - two-bit oscillator bias, four settings
// - LO pump current is (code+1) steps
// - LO fast-acquire enable turns on boosting
// - standby bits reset set, zero powers up
module synth_charge_pump_ctrl
    import synth_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk_in,
    input  wire logic          rst_b_in,
    // serial control port
    input  wire logic          spi_sclk_in,
    input  wire logic          spi_cs_b_in,
    input  wire logic          spi_sdi_in,
    output logic               spi_sdo_out,
    output logic               spi_sdo_oe_out,
    // phase comparator pulses
    input  wire logic          lo_pfd_up_in,
    input  wire logic          lo_pfd_dn_in,
    input  wire logic          clk_pfd_up_in,
    input  wire logic          clk_pfd_dn_in,
    // pump drives
    output pump_drive_t        lo_pump_out,
    output pump_drive_t        clk_pump_out,
    // divided references
    output logic               lo_ref_tick_out,
    output logic               clk_ref_tick_out,
    // divider settings to the loops
    output logic [REF_W-1:0]   lo_ref_divider_out,
    output logic [2:0]         lo_swallow_count_out,
    output logic [FB_W-1:0]    lo_main_count_out,
    output logic [REF_W-1:0]   clk_ref_divider_out,
    output logic [FB_W-1:0]    clk_feedback_divider_out,
    output logic [1:0]         lo_test_select_out,
    output logic [1:0]         clk_test_select_out,
    // standby and bias
    output logic [7:0]         block_standby_out,
    output logic [1:0]         oscillator_bias_select_out
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 7;
    wire  [NSYNC-1:0] raw_in = {spi_sclk_in, spi_cs_b_in, spi_sdi_in,
                                lo_pfd_up_in, lo_pfd_dn_in, clk_pfd_up_in, clk_pfd_dn_in};
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
                meta_ff[i] <= (i == 5);
                sync_ff[i] <= (i == 5);
            end else begin
                meta_ff[i] <= raw_in[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    wire sclk_s   = sync_ff[6];
    wire cs_b_s   = sync_ff[5];
    wire sdi_s    = sync_ff[4];
    wire lo_up_s  = sync_ff[3];
    wire lo_dn_s  = sync_ff[2];
    wire ck_up_s  = sync_ff[1];
    wire ck_dn_s  = sync_ff[0];

    // ------------------------------------------------------------
    // serial frame: r/w, 7-bit address, 8-bit data, msb first
    // ------------------------------------------------------------
    spi_state_t   state_ff;
    logic         sclk_d_ff;
    logic [4:0]   bitcnt_ff;
    logic [14:0]  shift_ff;
    logic [7:0]   rd_sh_ff;
    logic         sdo_ff;
    logic         sdo_oe_ff;

    wire        rise      = sclk_s && !sclk_d_ff;
    wire        fall      = !sclk_s && sclk_d_ff;
    wire [15:0] frame     = {shift_ff, sdi_s};
    wire        head_done = rise && (bitcnt_ff == 5'd7);
    wire        data_done = rise && (bitcnt_ff == 5'(FRAME_W - 1));
    wire        is_read   = shift_ff[6];
    wire        wr_stb    = (state_ff == SPI_WDATA) && data_done && !cs_b_s;
    wire [6:0]  wr_addr   = frame[ADDR_MSB:ADDR_LSB];
    wire [7:0]  wr_data   = frame[7:0];
    wire [6:0]  rd_addr   = frame[6:0];

    spi_state_t nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SPI_IDLE:  nxt_state = cs_b_s ? SPI_IDLE : SPI_HEAD;
            SPI_HEAD:  nxt_state = !head_done ? SPI_HEAD : (is_read ? SPI_RDATA : SPI_WDATA);
            SPI_WDATA: nxt_state = data_done ? SPI_IDLE : SPI_WDATA;
            SPI_RDATA: nxt_state = data_done ? SPI_IDLE : SPI_RDATA;
            default:   nxt_state = SPI_IDLE;
        endcase
        if (cs_b_s) begin
            nxt_state = SPI_IDLE;
        end
    end

    wire [4:0]  nxt_bitcnt = (cs_b_s || state_ff == SPI_IDLE) ? 5'd0 :
                             rise ? bitcnt_ff + 5'd1 : bitcnt_ff;
    wire [14:0] nxt_shift  = rise ? frame[14:0] : shift_ff;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0]       block_standby_ff;
    logic [1:0]       bias_ff;
    logic [REF_W-1:0] lo_r_ff;
    logic [2:0]       lo_a_ff;
    logic [FB_W-1:0]  lo_b_ff;
    logic [7:0]       lo_ctl_ff;
    logic [REF_W-1:0] lo_fa_ff;
    logic [REF_W-1:0] ck_r_ff;
    logic [FB_W-1:0]  ck_n_ff;
    logic [7:0]       ck_ctl_ff;
    logic [REF_W-1:0] ck_fa_ff;

    wire wr_block_standby   = wr_stb && wr_addr == BLOCK_STANDBY_ADDR;
    wire wr_bias   = wr_stb && wr_addr == OSCILLATOR_BIAS_SELECT_ADDR;
    wire wr_lo_rh  = wr_stb && wr_addr == LO_REF_DIVIDER_HIGH_ADDR;
    wire wr_lo_rl  = wr_stb && wr_addr == LO_REF_DIVIDER_LOW_ADDR;
    wire wr_lo_ab  = wr_stb && wr_addr == LO_SWALLOW_AND_MAIN_HIGH_ADDR;
    wire wr_lo_bl  = wr_stb && wr_addr == LO_MAIN_COUNT_LOW_ADDR;
    wire wr_lo_ctl = wr_stb && wr_addr == LO_PUMP_CONTROL_ADDR;
    wire wr_lo_fh  = wr_stb && wr_addr == LO_FASTACQ_DIVISOR_HIGH_ADDR;
    wire wr_lo_fl  = wr_stb && wr_addr == LO_FASTACQ_DIVISOR_LOW_ADDR;
    wire wr_ck_rh  = wr_stb && wr_addr == CLK_REF_DIVIDER_HIGH_ADDR;
    wire wr_ck_rl  = wr_stb && wr_addr == CLK_REF_DIVIDER_LOW_ADDR;
    wire wr_ck_nh  = wr_stb && wr_addr == CLK_FEEDBACK_DIVIDER_HIGH_ADDR;
    wire wr_ck_nl  = wr_stb && wr_addr == CLK_FEEDBACK_DIVIDER_LOW_ADDR;
    wire wr_ck_ctl = wr_stb && wr_addr == CLK_PUMP_CONTROL_ADDR;
    wire wr_ck_fh  = wr_stb && wr_addr == CLK_FASTACQ_DIVISOR_HIGH_ADDR;
    wire wr_ck_fl  = wr_stb && wr_addr == CLK_FASTACQ_DIVISOR_LOW_ADDR;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            block_standby_ff   <= BLOCK_STANDBY_RST;
            bias_ff   <= OSC_BIAS_RST;
            lo_r_ff   <= REF_DIVIDER_RST;
            lo_a_ff   <= LO_SWALLOW_RST;
            lo_b_ff   <= LO_MAIN_RST;
            lo_ctl_ff <= PUMP_CONTROL_RST;
            lo_fa_ff  <= FASTACQ_DIVISOR_RST;
            ck_r_ff   <= REF_DIVIDER_RST;
            ck_n_ff   <= CLK_FEEDBACK_RST;
            ck_ctl_ff <= PUMP_CONTROL_RST;
            ck_fa_ff  <= FASTACQ_DIVISOR_RST;
        end else begin
            if (wr_block_standby)   block_standby_ff <= wr_data;
            if (wr_bias)   bias_ff <= wr_data[OSC_BIAS_LSB +: 2];
            if (wr_lo_rh)  lo_r_ff[13:8] <= wr_data[5:0];
            if (wr_lo_rl)  lo_r_ff[7:0] <= wr_data;
            if (wr_lo_ab)  lo_a_ff <= wr_data[SWALLOW_LSB +: 3];
            if (wr_lo_ab)  lo_b_ff[12:8] <= wr_data[4:0];
            if (wr_lo_bl)  lo_b_ff[7:0] <= wr_data;
            if (wr_lo_ctl) lo_ctl_ff <= {1'b0, wr_data[6:0]};
            if (wr_lo_fh)  lo_fa_ff[13:8] <= {2'h0, wr_data[3:0]};
            if (wr_lo_fl)  lo_fa_ff[7:0] <= wr_data;
            if (wr_ck_rh)  ck_r_ff[13:8] <= wr_data[5:0];
            if (wr_ck_rl)  ck_r_ff[7:0] <= wr_data;
            if (wr_ck_nh)  ck_n_ff[12:8] <= wr_data[4:0];
            if (wr_ck_nl)  ck_n_ff[7:0] <= wr_data;
            if (wr_ck_ctl) ck_ctl_ff <= {1'b0, wr_data[6:0]};
            if (wr_ck_fh)  ck_fa_ff[13:8] <= {2'h0, wr_data[3:0]};
            if (wr_ck_fl)  ck_fa_ff[7:0] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // read-back, unmapped reads as zero
    // ------------------------------------------------------------
    logic [7:0] rd_data;
    always_comb begin
        case (rd_addr)
            BLOCK_STANDBY_ADDR:             rd_data = block_standby_ff;
            OSCILLATOR_BIAS_SELECT_ADDR:    rd_data = {4'h0, bias_ff, 2'h0};
            LO_REF_DIVIDER_HIGH_ADDR:       rd_data = {2'h0, lo_r_ff[13:8]};
            LO_REF_DIVIDER_LOW_ADDR:        rd_data = lo_r_ff[7:0];
            LO_SWALLOW_AND_MAIN_HIGH_ADDR:  rd_data = {lo_a_ff, lo_b_ff[12:8]};
            LO_MAIN_COUNT_LOW_ADDR:         rd_data = lo_b_ff[7:0];
            LO_PUMP_CONTROL_ADDR:           rd_data = lo_ctl_ff;
            LO_FASTACQ_DIVISOR_HIGH_ADDR:   rd_data = {2'h0, lo_fa_ff[13:8]};
            LO_FASTACQ_DIVISOR_LOW_ADDR:    rd_data = lo_fa_ff[7:0];
            CLK_REF_DIVIDER_HIGH_ADDR:      rd_data = {2'h0, ck_r_ff[13:8]};
            CLK_REF_DIVIDER_LOW_ADDR:       rd_data = ck_r_ff[7:0];
            CLK_FEEDBACK_DIVIDER_HIGH_ADDR: rd_data = {3'h0, ck_n_ff[12:8]};
            CLK_FEEDBACK_DIVIDER_LOW_ADDR:  rd_data = ck_n_ff[7:0];
            CLK_PUMP_CONTROL_ADDR:          rd_data = ck_ctl_ff;
            CLK_FASTACQ_DIVISOR_HIGH_ADDR:  rd_data = {2'h0, ck_fa_ff[13:8]};
            CLK_FASTACQ_DIVISOR_LOW_ADDR:   rd_data = ck_fa_ff[7:0];
            default:                        rd_data = 8'h00;
        endcase
    end

    wire        load_rd   = head_done && is_read && state_ff == SPI_HEAD;
    wire [7:0]  nxt_rd_sh = load_rd ? rd_data :
                            (fall && state_ff == SPI_RDATA) ? {rd_sh_ff[6:0], 1'b0} : rd_sh_ff;
    wire        nxt_sdo   = (fall && state_ff == SPI_RDATA) ? rd_sh_ff[7] : sdo_ff;
    wire        nxt_oe    = (state_ff == SPI_RDATA) && !cs_b_s;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_ff  <= SPI_IDLE;
            sclk_d_ff <= 1'b0;
            bitcnt_ff <= 5'd0;
            shift_ff  <= 15'h0000;
            rd_sh_ff  <= 8'h00;
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            sclk_d_ff <= sclk_s;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff  <= nxt_shift;
            rd_sh_ff  <= nxt_rd_sh;
            sdo_ff    <= nxt_sdo;
            sdo_oe_ff <= nxt_oe;
        end
    end

    // ------------------------------------------------------------
    // reference dividers
    // ------------------------------------------------------------
    logic [REF_W-1:0] lo_rc_ff;
    logic [REF_W-1:0] ck_rc_ff;
    logic             lo_tick_ff;
    logic             ck_tick_ff;

    wire lo_wrap = lo_rc_ff >= lo_r_ff - REF_W'(1) || lo_r_ff == '0;
    wire ck_wrap = ck_rc_ff >= ck_r_ff - REF_W'(1) || ck_r_ff == '0;
    wire lo_off  = block_standby_ff[SB_LO_BIT];
    wire ck_off  = block_standby_ff[SB_CK_BIT];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            lo_rc_ff   <= '0;
            ck_rc_ff   <= '0;
            lo_tick_ff <= 1'b0;
            ck_tick_ff <= 1'b0;
        end else begin
            lo_rc_ff   <= (lo_off || lo_wrap) ? '0 : lo_rc_ff + REF_W'(1);
            ck_rc_ff   <= (ck_off || ck_wrap) ? '0 : ck_rc_ff + REF_W'(1);
            lo_tick_ff <= !lo_off && lo_wrap;
            ck_tick_ff <= !ck_off && ck_wrap;
        end
    end

    // ------------------------------------------------------------
    // fast-acquire channels
    // ------------------------------------------------------------
    pump_ctl_t lo_ctl;
    pump_ctl_t ck_ctl;
    assign lo_ctl = {lo_ctl_ff[PUMP_FA_EN_BIT], lo_ctl_ff[PUMP_INVERT_BIT],
                     lo_ctl_ff[PUMP_CODE_LSB +: 3], lo_ctl_ff[PUMP_TEST_LSB +: 2]};
    assign ck_ctl = {ck_ctl_ff[PUMP_FA_EN_BIT], ck_ctl_ff[PUMP_INVERT_BIT],
                     ck_ctl_ff[PUMP_CODE_LSB +: 3], ck_ctl_ff[PUMP_TEST_LSB +: 2]};

    fast_acq_chan #(
        .DIV_W      (REF_W)
    ) u_lo_fa (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .up_in      (lo_up_s),
        .dn_in      (lo_dn_s),
        .divisor_in (lo_fa_ff),
        .ctl_in     (lo_ctl),
        .standby_in (lo_off),
        .pump_out   (lo_pump_out)
    );

    fast_acq_chan #(
        .DIV_W      (REF_W)
    ) u_ck_fa (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .up_in      (ck_up_s),
        .dn_in      (ck_dn_s),
        .divisor_in (ck_fa_ff),
        .ctl_in     (ck_ctl),
        .standby_in (ck_off),
        .pump_out   (clk_pump_out)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spi_sdo_out                = sdo_ff;
    assign spi_sdo_oe_out             = sdo_oe_ff;
    assign lo_ref_tick_out            = lo_tick_ff;
    assign clk_ref_tick_out           = ck_tick_ff;
    assign lo_ref_divider_out         = lo_r_ff;
    assign lo_swallow_count_out       = lo_a_ff;
    assign lo_main_count_out          = lo_b_ff;
    assign clk_ref_divider_out        = ck_r_ff;
    assign clk_feedback_divider_out   = ck_n_ff;
    assign lo_test_select_out         = lo_ctl_ff[PUMP_TEST_LSB +: 2];
    assign clk_test_select_out        = ck_ctl_ff[PUMP_TEST_LSB +: 2];
    assign block_standby_out          = block_standby_ff;
    assign oscillator_bias_select_out = bias_ff;

endmodule

// *** tb/cp_ctrl_sva.sv ***
`timescale 1ns/1ns
module cp_ctrl_sva
    import synth_ctrl_pkg::*;
(
    // clock and reset
    input wire logic             sys_clk_in,
    input wire logic             rst_b_in,
    // pulses and drives
    input wire logic             clk_pfd_up_in,
    input wire logic             clk_pfd_dn_in,
    input wire pump_drive_t      lo_pump_out,
    input wire pump_drive_t      clk_pump_out,
    // ticks and settings
    input wire logic             lo_ref_tick_out,
    input wire logic             clk_ref_tick_out,
    input wire logic [REF_W-1:0] clk_ref_divider_out,
    input wire logic [7:0]       block_standby_out
);
    // ------------
    // tick gap counter
    // ------------
    logic [REF_W-1:0] gap_ff;
    logic             armed_ff;
    wire              ck_sb = block_standby_out[SB_CK_BIT];
    always_ff @(posedge sys_clk_in) begin
        gap_ff   <= clk_ref_tick_out ? '0 : gap_ff + 1'b1;
        armed_ff <= rst_b_in && !ck_sb && (clk_ref_tick_out || armed_ff)
                    && $stable(clk_ref_divider_out);
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // ------------
    // properties
    // ------------
    sequence s_ck_off; ck_sb [*3]; endsequence
    sequence s_ck_pulse; ((clk_pfd_up_in || clk_pfd_dn_in) && !ck_sb) [*4]; endsequence
    property p_ck_quiet; s_ck_off |-> !clk_pump_out.drive_en && !clk_pump_out.up
        && !clk_pump_out.dn && !clk_ref_tick_out; endproperty
    a_ck_quiet: assert property (p_ck_quiet) else $error("clk pump active in standby");
    property p_ck_on; !ck_sb [*3] |-> clk_pump_out.drive_en; endproperty
    a_ck_on: assert property (p_ck_on) else $error("clk pump not powered");
    property p_lo_quiet; block_standby_out[SB_LO_BIT] [*3] |-> !lo_pump_out.drive_en
        && !lo_ref_tick_out; endproperty
    a_lo_quiet: assert property (p_lo_quiet) else $error("lo pump active in standby");
    property p_lo_on; !block_standby_out[SB_LO_BIT] [*3] |-> lo_pump_out.drive_en; endproperty
    a_lo_on: assert property (p_lo_on) else $error("lo pump not powered");
    property p_cap; lo_pump_out.units <= MAX_UNITS && clk_pump_out.units <= MAX_UNITS;
    endproperty
    a_cap: assert property (p_cap) else $error("units above eight");
    property p_tick_one; lo_ref_tick_out |=> !lo_ref_tick_out; endproperty
    a_tick_one: assert property (p_tick_one) else $error("lo tick too long");
    property p_ck_period; clk_ref_tick_out && armed_ff |-> gap_ff == clk_ref_divider_out - 1'b1;
    endproperty
    a_ck_period: assert property (p_ck_period) else $error("clk tick period wrong");
    property p_follow; s_ck_pulse |-> clk_pump_out.up || clk_pump_out.dn; endproperty
    a_follow: assert property (p_follow) else $error("clk pump ignores pulse");
endmodule

bind synth_charge_pump_ctrl cp_ctrl_sva chk_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .clk_pfd_up_in(clk_pfd_up_in), .clk_pfd_dn_in(clk_pfd_dn_in), .lo_pump_out(lo_pump_out),
    .clk_pump_out(clk_pump_out), .lo_ref_tick_out(lo_ref_tick_out),
    .clk_ref_tick_out(clk_ref_tick_out), .clk_ref_divider_out(clk_ref_divider_out),
    .block_standby_out(block_standby_out));

// *** tb/pfd_model.sv ***
`timescale 1ns/1ns
module pfd_model (
    // control
    input  wire logic       sys_clk_in,
    input  wire logic       go_in,
    input  wire logic [7:0] width_in,
    input  wire logic       sel_clk_in,
    input  wire logic       late_in,
    // comparator pulses
    output logic            lo_up_out,
    output logic            lo_dn_out,
    output logic            clk_up_out,
    output logic            clk_dn_out
);
    logic [7:0] left_ff = 8'h00;
    wire        busy = left_ff != 8'h00;
    always_ff @(posedge sys_clk_in) begin
        if (go_in) left_ff <= width_in;
        else if (busy) left_ff <= left_ff - 8'h01;
    end
    assign lo_up_out  = busy && !sel_clk_in && !late_in;
    assign lo_dn_out  = busy && !sel_clk_in && late_in;
    assign clk_up_out = busy && sel_clk_in && !late_in;
    assign clk_dn_out = busy && sel_clk_in && late_in;
endmodule

// *** tb/tb_synth_charge_pump_fast_acquire.sv ***
`timescale 1ns/1ns
module tb_synth_charge_pump_fast_acquire;
    import synth_ctrl_pkg::*;
    logic        sys_clk_in = 0, rst_b_in = 0, sclk = 0, cs_b = 1, sdi = 0;
    logic        go = 0, sel = 0, late = 0, obs_v = 0, sdo, lu, ld, cu, cd;
    logic [7:0]  width = 0, obs, rd, b, d, m, e, block_standby, exp_q[$];
    logic [1:0]  bias;
    pump_drive_t lo_p, ck_p;
    int          failures = 0, num_checks = 0;
    logic [7:0]  ra[17] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
                            8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    logic [7:0]  rv[17] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h38, 8'ha0, 8'h1d, 8'h00, 8'h00,
                            8'h04, 8'h00, 8'h38, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h04};
    logic [7:0]  cv[3] = '{8'h40, 8'h4c, 8'h14};
    initial forever #50 sys_clk_in = ~sys_clk_in;
    pfd_model pm_u (.sys_clk_in(sys_clk_in), .go_in(go), .width_in(width), .sel_clk_in(sel),
        .late_in(late), .lo_up_out(lu), .lo_dn_out(ld), .clk_up_out(cu), .clk_dn_out(cd));
    synth_charge_pump_ctrl dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .spi_sclk_in(sclk), .spi_cs_b_in(cs_b), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
        .spi_sdo_oe_out(), .lo_pfd_up_in(lu), .lo_pfd_dn_in(ld), .clk_pfd_up_in(cu),
        .clk_pfd_dn_in(cd), .lo_pump_out(lo_p), .clk_pump_out(ck_p), .lo_ref_tick_out(),
        .clk_ref_tick_out(), .lo_ref_divider_out(), .lo_swallow_count_out(),
        .lo_main_count_out(), .clk_ref_divider_out(), .clk_feedback_divider_out(),
        .lo_test_select_out(), .clk_test_select_out(), .block_standby_out(block_standby),
        .oscillator_bias_select_out(bias));
    // ------------
    // helpers
    // ------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    always @(posedge sys_clk_in) if (obs_v) check(obs, exp_q.pop_front());
    task automatic note(input logic [7:0] v);
        @(posedge sys_clk_in) obs <= v;
        obs_v <= 1'b1;
        @(posedge sys_clk_in) obs_v <= 1'b0;
    endtask
    task automatic frame(input logic [15:0] f);
        @(posedge sys_clk_in) cs_b <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge sys_clk_in) sdi <= f[i];
            tick(5);
            if (i < 8) rd[i] = sdo;
            sclk <= 1'b1;
            tick(5);
            sclk <= 1'b0;
        end
        tick(6);
        cs_b <= 1'b1;
        tick(5);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        frame({1'b1, a[6:0], 8'h00});
        note(rd);
    endtask
    task automatic pulse(input logic [7:0] w, input logic [7:0] want, input logic ch);
        @(posedge sys_clk_in) width <= w;
        go <= 1'b1;
        sel <= ch;
        late <= w[0];
        @(posedge sys_clk_in) go <= 1'b0;
        tick(w + 8);
        exp_q.push_back(want);
        note({4'h0, ch ? ck_p.units : lo_p.units});
    endtask
    task automatic results();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        for (int w = 0; w < 90000; w++) @(posedge sys_clk_in);
        failures++;
        results();
    end
    // ------------
    // scenarios
    // ------------
    initial begin
        void'($urandom(3062));
        tick(20);
        rst_b_in <= 1'b1;
        tick(2);
        foreach (ra[i]) rdchk(ra[i], rv[i]);
        b = 8'($urandom());
        frame({8'h01, b});
        exp_q.push_back({6'h00, b[3:2]});
        note({6'h00, bias});
        rdchk(8'h01, b & 8'h0c);
        frame(16'h0000);
        exp_q.push_back(8'h00);
        note(block_standby);
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 6; k++) begin
                d = k[0] ? 8'h0a : 8'h05;
                m = cv[k/2];
                frame({c[0] ? 8'h16 : 8'h0e, d});
                frame({c[0] ? 8'h14 : 8'h0c, m});
                for (int n = 0; n < 9; n++) begin
                    e = {5'h00, m[4:2]} + 8'h01;
                    if (m[6] && e < 8'h02) e = 8'h02;
                    if (m[6] && e < n + 1) e = (n > 7) ? 8'h08 : 8'(n + 1);
                    pulse(8'(d * n + 2), e, c[0]);
                end
            end
        end
        tick(4);
        results();
    end
endmodule
